/* File: pwl_pkg.sv */
// Purpose: Shared constants and types for the piecewise linear conversion block
// Assumes: Normalized values are unsigned Q1.15, 16'h8000 is full scale (1.0)
// Notes: Register offsets are byte offsets inside one channel window
`default_nettype none
package pwl_pkg;
  // ****************************************
  // Sizes
  // ****************************************
  localparam int NUM_CH = 4;
  localparam int NUM_PT = 11;
  localparam int LAST_PT = 10;
  localparam int NUM_SRC = 8;
  localparam logic [15:0] FULL_SCALE = 16'h8000;
  localparam logic [13:0] HOT_DLY_MAX = 14'h2710;
  localparam logic [4:0] DIV_STEPS = 5'h10;

  // ****************************************
  // Timing
  // ****************************************
  localparam int HOT_UNIT_NS = 1000000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int HOT_UNIT_CYC = (HOT_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOT_PRE_W = 17;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [11:0] MAP_END = 12'h200;
  localparam logic [6:0] OFS_CFG = 7'h00;
  localparam logic [6:0] OFS_STATE = 7'h04;
  localparam logic [6:0] OFS_HOT_DLY = 7'h08;
  localparam logic [6:0] OFS_HOT_Y = 7'h0C;
  localparam logic [6:0] OFS_STATUS = 7'h10;
  localparam logic [6:0] OFS_INPUT = 7'h14;
  localparam logic [6:0] OFS_POINT0 = 7'h20;
  localparam logic [6:0] OFS_POINT_LAST = 7'h48;
  localparam int CFG_INV_BIT = 8;
  localparam int PT_X_LSB = 16;
  localparam int STAT_FLAG_BIT = 16;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [3:0] RST_SRC = 4'h0;
  localparam logic [10:0] RST_STATE = 11'h401;
  localparam logic [10:0][15:0] RST_PT_X = {16'h8000, 16'h7333, 16'h6666, 16'h599A,
    16'h4CCD, 16'h4000, 16'h3333, 16'h2666, 16'h199A, 16'h0CCD, 16'h0000};
  localparam logic [15:0] RST_Y = 16'h0000;
  localparam logic [13:0] RST_HOT_DLY = 14'h0000;

  // ****************************************
  // Types
  // ****************************************
  typedef logic [15:0] pwl_norm_t;
  typedef struct packed {
    logic [10:0] on;
    logic [10:0][15:0] x;
    logic [10:0][15:0] y;
  } pwl_curve_s;
  typedef enum logic [1:0] {
    EV_LOAD = 2'b00,
    EV_SEARCH = 2'b01,
    EV_DIV = 2'b10,
    EV_DONE = 2'b11
  } pwl_eval_e;
endpackage
`default_nettype wire

/* File: pwl_eval.sv */
// Purpose: Evaluates one piecewise linear curve for a sampled input, over and over
// Assumes: Input clipped to full scale, point 10 active at full scale
// Notes: Serial search plus 16 step division keeps the area of one channel small
`default_nettype none
`timescale 1ns/1ps
module pwl_eval import pwl_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire pwl_norm_t x_i,
  input wire pwl_curve_s curve_i,
  output pwl_norm_t y_o,
  output logic done_o
);
  pwl_eval_e state;
  logic [3:0] idx;
  logic [3:0] lo_idx;
  logic [10:0] on_s;
  pwl_norm_t x_s;
  pwl_norm_t y_base;
  pwl_norm_t den;
  pwl_norm_t rem;
  pwl_norm_t quo;
  pwl_norm_t num_lo;
  logic neg;
  logic [4:0] step;
  logic hit;
  pwl_norm_t y_hi;
  pwl_norm_t y_lo;
  pwl_norm_t dy_abs;
  logic [31:0] prod;
  logic [16:0] trial;

  // ****************************************
  // Segment arithmetic
  // ****************************************
  always_comb begin
    y_hi = curve_i.y[idx];
    y_lo = curve_i.y[lo_idx];
    hit = (on_s[idx] && (curve_i.x[idx] >= x_s)) || (idx == 4'(LAST_PT));
    dy_abs = (y_hi >= y_lo) ? 16'(y_hi - y_lo) : 16'(y_lo - y_hi);
    prod = dy_abs * 16'(x_s - curve_i.x[lo_idx]);
    trial = {rem, num_lo[15]};
  end

  // ****************************************
  // Sequencer
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= EV_LOAD;
      idx <= 4'h1;
      lo_idx <= 4'h0;
      on_s <= RST_STATE;
      x_s <= 16'h0000;
      y_base <= 16'h0000;
      den <= 16'h0000;
      rem <= 16'h0000;
      quo <= 16'h0000;
      num_lo <= 16'h0000;
      neg <= 1'b0;
      step <= 5'h00;
      y_o <= 16'h0000;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      unique case (state)
        EV_LOAD: begin
          x_s <= x_i;
          // Flags held for the whole pass, so a write mid-pass cannot strand the segment start
          on_s <= curve_i.on;
          idx <= 4'h1;
          lo_idx <= 4'h0;
          state <= EV_SEARCH;
        end
        EV_SEARCH: begin
          if (hit) begin
            // Equal neighbours give no slope, so take the upper point as is
            if (curve_i.x[idx] == curve_i.x[lo_idx]) begin
              y_base <= y_hi;
              neg <= 1'b0;
              quo <= 16'h0000;
              state <= EV_DONE;
            end else begin
              y_base <= y_lo;
              neg <= (y_hi < y_lo);
              den <= 16'(curve_i.x[idx] - curve_i.x[lo_idx]);
              rem <= prod[31:16];
              num_lo <= prod[15:0];
              quo <= 16'h0000;
              step <= 5'h00;
              state <= EV_DIV;
            end
          end else begin
            if (on_s[idx]) begin
              lo_idx <= idx;
            end
            idx <= 4'(idx + 4'h1);
          end
        end
        EV_DIV: begin
          if (trial >= {1'b0, den}) begin
            rem <= 16'(trial - {1'b0, den});
            quo <= {quo[14:0], 1'b1};
          end else begin
            rem <= trial[15:0];
            quo <= {quo[14:0], 1'b0};
          end
          num_lo <= {num_lo[14:0], 1'b0};
          step <= 5'(step + 5'h01);
          if (step == 5'(DIV_STEPS - 5'h01)) begin
            state <= EV_DONE;
          end
        end
        EV_DONE: begin
          y_o <= neg ? 16'(y_base - quo) : 16'(y_base + quo);
          done_o <= 1'b1;
          state <= EV_LOAD;
        end
      endcase
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_eval_latency: assert property (
    state == EV_LOAD |-> ##[3:28] done_o)
    else $error("curve evaluation overran its latency");
  a_lo_active: assert property (
    state == EV_DIV |-> on_s[lo_idx])
    else $error("inactive point used as segment start");
  c_div_path: cover property (state == EV_SEARCH ##1 state == EV_DIV);
endmodule
`default_nettype wire

/* File: pwl_conv.sv */
// Purpose: Four channel piecewise linear conversion with hotshot, APB configured
// Assumes: APB master keeps to the protocol; sources are normalized Q1.15 values
// Notes: Zero wait state slave; output lags input by one evaluation pass
// Function
// - There are four independent conversion channels, each with its own settings.
// - Each channel turns one normalized input into one normalized output.
// - A source select picks the feeding signal, and unconnected (default) feeds nothing.
// - An invert setting, off by default, uses one minus the input before the curve.
// - The curve is piecewise linear through at most eleven breakpoints.
// - Breakpoints 0 to 10 each hold an on flag, an input and an output coordinate.
// - Breakpoints that are off are skipped so interpolation uses the next active one.
// - Between two neighbouring active points the output lies on the line joining them.
// - The last breakpoint has a normal output and a separate hotshot output.
// - Input held at full scale longer than the hotshot delay gives the hotshot output; here a delay of 0 turns the hotshot off.
//
// The implementer's own choices: the placing of the registers and the APB register port.
`default_nettype none
`timescale 1ns/1ps
module pwl_conv import pwl_pkg::*; #(
  parameter int unsigned MS_CYCLES = HOT_UNIT_CYC
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire pwl_norm_t [NUM_SRC-1:0] SRC_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output pwl_norm_t [NUM_CH-1:0] OUT_O,
  output logic [NUM_CH-1:0] HOT_O
);
  // ****************************************
  // Configuration state
  // ****************************************
  logic [NUM_CH-1:0][3:0] src_sel;
  logic [NUM_CH-1:0] inv;
  logic [NUM_CH-1:0][10:0] pt_on;
  logic [NUM_CH-1:0][10:0][15:0] pt_x;
  logic [NUM_CH-1:0][10:0][15:0] pt_y;
  logic [NUM_CH-1:0][13:0] hot_dly;
  pwl_norm_t [NUM_CH-1:0] hot_y;
  pwl_curve_s curve [NUM_CH];

  // ****************************************
  // Datapath signals
  // ****************************************
  pwl_norm_t [NUM_CH-1:0] raw;
  pwl_norm_t [NUM_CH-1:0] x_eff;
  logic [NUM_CH-1:0] at_full;
  logic [NUM_CH-1:0] hot_act;
  logic [NUM_CH-1:0][13:0] hot_cnt;
  logic [HOT_PRE_W-1:0] pre;
  logic tick;
  pwl_norm_t ev_y [NUM_CH];
  logic [NUM_CH-1:0] ev_done;

  // ****************************************
  // Bus decode signals
  // ****************************************
  logic [1:0] ch;
  logic [6:0] ofs;
  logic [6:0] pt_ofs;
  logic [3:0] pt;
  logic hit;
  logic [31:0] rd_cur;
  logic [31:0] wmask;
  logic [31:0] wval;
  logic setup;
  logic wr_go;

  function automatic pwl_norm_t clip(input logic [15:0] v);
    clip = (v > FULL_SCALE) ? FULL_SCALE : v;
  endfunction

  // ****************************************
  // Register decode
  // ****************************************
  always_comb begin
    ch = PADDR_I[8:7];
    ofs = PADDR_I[6:0];
    pt_ofs = 7'(ofs - OFS_POINT0);
    pt = pt_ofs[5:2];
    hit = 1'b0;
    rd_cur = 32'h0000_0000;
    if ((PADDR_I < MAP_END) && (PADDR_I[1:0] == 2'h0)) begin
      hit = 1'b1;
      if (ofs == OFS_CFG) begin
        rd_cur[3:0] = src_sel[ch];
        rd_cur[CFG_INV_BIT] = inv[ch];
      end else if (ofs == OFS_STATE) begin
        rd_cur[10:0] = pt_on[ch];
      end else if (ofs == OFS_HOT_DLY) begin
        rd_cur[13:0] = hot_dly[ch];
      end else if (ofs == OFS_HOT_Y) begin
        rd_cur[15:0] = hot_y[ch];
      end else if (ofs == OFS_STATUS) begin
        rd_cur[15:0] = OUT_O[ch];
        rd_cur[STAT_FLAG_BIT] = HOT_O[ch];
      end else if (ofs == OFS_INPUT) begin
        rd_cur[15:0] = x_eff[ch];
        rd_cur[STAT_FLAG_BIT] = at_full[ch];
      end else if ((ofs >= OFS_POINT0) && (ofs <= OFS_POINT_LAST)) begin
        rd_cur[15:0] = pt_y[ch][pt];
        rd_cur[PT_X_LSB+:16] = pt_x[ch][pt];
      end else begin
        hit = 1'b0;
      end
    end
    wmask = {{8{PSTRB_I[3]}}, {8{PSTRB_I[2]}}, {8{PSTRB_I[1]}}, {8{PSTRB_I[0]}}};
    wval = (PWDATA_I & wmask) | (rd_cur & ~wmask);
    setup = PSEL_I && !PENABLE_I;
    wr_go = PSEL_I && PENABLE_I && PWRITE_I && PREADY_O && !PSLVERR_O;
  end

  // ****************************************
  // APB answer
  // ****************************************
  // Answer is prepared in the setup cycle so every output is a flop
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      PREADY_O <= 1'b0;
      PSLVERR_O <= 1'b0;
      PRDATA_O <= 32'h0000_0000;
    end else begin
      PREADY_O <= setup;
      PSLVERR_O <= setup && !hit;
      PRDATA_O <= (setup && !PWRITE_I && hit) ? rd_cur : 32'h0000_0000;
    end
  end

  // ****************************************
  // Source and inversion settings
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      src_sel <= {NUM_CH{RST_SRC}};
      inv <= '0;
    end else if (wr_go && (ofs == OFS_CFG)) begin
      src_sel[ch] <= wval[3:0];
      inv[ch] <= wval[CFG_INV_BIT];
    end
  end

  // ****************************************
  // Breakpoint table
  // ****************************************
  // Points 0 and 10 keep their flag and input coordinate fixed
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pt_on <= {NUM_CH{RST_STATE}};
      pt_x <= {NUM_CH{RST_PT_X}};
      pt_y <= '0;
    end else if (wr_go) begin
      if (ofs == OFS_STATE) begin
        pt_on[ch][9:1] <= wval[9:1];
      end
      if ((ofs >= OFS_POINT0) && (ofs <= OFS_POINT_LAST)) begin
        pt_y[ch][pt] <= clip(wval[15:0]);
        if ((pt != 4'h0) && (pt != 4'(LAST_PT))) begin
          pt_x[ch][pt] <= clip(wval[PT_X_LSB+:16]);
        end
      end
    end
  end

  // ****************************************
  // Hotshot settings
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hot_dly <= {NUM_CH{RST_HOT_DLY}};
      hot_y <= {NUM_CH{RST_Y}};
    end else if (wr_go) begin
      if (ofs == OFS_HOT_DLY) begin
        hot_dly[ch] <= (wval > 32'(HOT_DLY_MAX)) ? HOT_DLY_MAX : wval[13:0];
      end
      if (ofs == OFS_HOT_Y) begin
        hot_y[ch] <= clip(wval[15:0]);
      end
    end
  end

  // ****************************************
  // Input selection
  // ****************************************
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      raw[c] = 16'h0000;
      if ((src_sel[c] != 4'h0) && (src_sel[c] <= 4'(NUM_SRC))) begin
        raw[c] = clip(SRC_I[3'(src_sel[c] - 4'h1)]);
      end
      x_eff[c] = inv[c] ? 16'(FULL_SCALE - raw[c]) : raw[c];
      at_full[c] = (x_eff[c] == FULL_SCALE);
      hot_act[c] = at_full[c] && (hot_dly[c] != 14'h0000) && (hot_cnt[c] > hot_dly[c]);
    end
  end

  // ****************************************
  // Channel evaluators
  // ****************************************
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    always_comb begin
      curve[g].on = pt_on[g];
      curve[g].x = pt_x[g];
      curve[g].y = pt_y[g];
    end
    pwl_eval u_eval (
      .clk_i(CLK_I),
      .rst_n_i(RST_N_I),
      .x_i(x_eff[g]),
      .curve_i(curve[g]),
      .y_o(ev_y[g]),
      .done_o(ev_done[g])
    );
  end

  // ****************************************
  // Hotshot timing
  // ****************************************
  // Free running millisecond tick, so the first count may come early by up to 1 ms
  assign tick = (pre == HOT_PRE_W'(MS_CYCLES - 1));

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pre <= '0;
    end else begin
      pre <= tick ? '0 : HOT_PRE_W'(pre + 1'b1);
    end
  end

  // Counter stops one past the delay, which is the strict longer-than test
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hot_cnt <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (!at_full[c] || (hot_dly[c] == 14'h0000)) begin
          hot_cnt[c] <= 14'h0000;
        end else if (tick && (hot_cnt[c] <= hot_dly[c])) begin
          hot_cnt[c] <= 14'(hot_cnt[c] + 14'h0001);
        end
      end
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      OUT_O <= '0;
      HOT_O <= '0;
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        HOT_O[c] <= hot_act[c];
        if (hot_act[c]) begin
          OUT_O[c] <= hot_y[c];
        end else if (ev_done[c]) begin
          OUT_O[c] <= ev_y[c];
        end
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  for (genvar k = 0; k < NUM_CH; k++) begin : g_chk
    a_src_unconn: assert property (
      (src_sel[k] == 4'h0) && !inv[k] |-> x_eff[k] == 16'h0000 && !at_full[k])
      else $error("unconnected input not zero");
    a_inv_sum: assert property (
      inv[k] |-> 17'(x_eff[k]) + 17'(raw[k]) == 17'(FULL_SCALE))
      else $error("inverted input wrong");
    a_ends_fixed: assert property (
      pt_on[k][0] && pt_x[k][0] == 16'h0000)
      else $error("first breakpoint changed");
    a_last_fixed: assert property (
      pt_on[k][LAST_PT] && pt_x[k][LAST_PT] == FULL_SCALE)
      else $error("last breakpoint changed");
    a_clip_range: assert property (
      hot_y[k] <= FULL_SCALE && pt_y[k][LAST_PT] <= FULL_SCALE && OUT_O[k] <= FULL_SCALE)
      else $error("value above full scale");
    a_hot_cause: assert property (
      HOT_O[k] |-> $past(at_full[k]) && $past(hot_cnt[k]) > $past(hot_dly[k]))
      else $error("hotshot without held full scale");
    a_hot_value: assert property (
      HOT_O[k] |-> OUT_O[k] == $past(hot_y[k]))
      else $error("hotshot value not shown");
    a_hot_zero: assert property (
      hot_dly[k] == 14'h0000 |=> !HOT_O[k])
      else $error("hotshot active with zero delay");
    a_hot_restart: assert property (
      !at_full[k] |=> hot_cnt[k] == 14'h0000 && !HOT_O[k])
      else $error("hotshot timer not restarted");
    a_curve_load: assert property (
      ev_done[k] && !hot_act[k] |=> OUT_O[k] == $past(ev_y[k]))
      else $error("curve result not shown");
  end

  c_hot_on: cover property (!HOT_O[0] ##1 HOT_O[0]);
  c_hot_off: cover property (HOT_O[1] ##1 !HOT_O[1]);
  c_inv_full: cover property (inv[2] && at_full[2] && ev_done[2]);
  c_apb_err: cover property (PSLVERR_O && PREADY_O);
endmodule
`default_nettype wire

/* File: pwl_src_model.sv */
// Purpose: Stand-in for the function blocks that feed the conversion inputs
// Assumes: Sources are plain Q1.15 levels
// Notes: A new level shows one clock after the load request
`timescale 1ns/1ps
`default_nettype none
module pwl_src_model import pwl_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic we_i,
  input wire logic [2:0] idx_i,
  input wire pwl_norm_t val_i,
  output pwl_norm_t [NUM_SRC-1:0] src_o
);
  // ****************
  // Source levels
  // ****************
  // Loads pass a flop, like a real upstream block, so no level moves on the sampling edge
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      src_o <= '0;
    end else if (we_i) begin
      src_o[idx_i] <= val_i;
    end
  end
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Purpose: Self-checking bench for the four channel conversion block
// Assumes: One millisecond shortened to 10 clocks
// Notes: Each scenario is a task that judges its own results
`timescale 1ns/1ps
`default_nettype none
module tb_top import pwl_pkg::*; ();
  // ****************
  // Signals
  // ****************
  localparam int unsigned MS = 10;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic swe = 1'b0;
  logic [2:0] sidx = 3'h0;
  pwl_norm_t sval = 16'h0000;
  pwl_norm_t [NUM_SRC-1:0] src;
  pwl_norm_t [NUM_CH-1:0] out;
  logic [NUM_CH-1:0] hot;
  logic [31:0] rd;
  logic err;
  int errors = 0;
  int cmp_count = 0;

  initial begin
    forever #4 clk = ~clk;
  end

  pwl_src_model i_src (.clk_i(clk), .rst_n_i(rst_n), .we_i(swe), .idx_i(sidx), .val_i(sval),
    .src_o(src));
  pwl_conv #(.MS_CYCLES(MS)) i_dut (.CLK_I(clk), .RST_N_I(rst_n), .SRC_I(src), .PSEL_I(psel),
    .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(4'hF),
    .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr), .OUT_O(out), .HOT_O(hot));

  // ****************
  // Shared tasks
  // ****************
  task automatic summarize();
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Polls pready rather than trusting a fixed latency
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    @(posedge clk);
  endtask

  task automatic wr(input int c, input logic [6:0] o, input logic [31:0] d);
    apb(1'b1, 12'(c * 128) + {5'h00, o}, d);
  endtask

  task automatic rdc(input string nm, input int c, input logic [6:0] o, input logic [31:0] e);
    apb(1'b0, 12'(c * 128) + {5'h00, o}, 32'h00000000);
    check(nm, rd, e);
  endtask

  task automatic set_src(input int i, input pwl_norm_t v);
    sidx <= 3'(i);
    sval <= v;
    swe <= 1'b1;
    @(posedge clk);
    swe <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wait_out(input int c, input pwl_norm_t e);
    for (int i = 0; i < 100 && out[c] !== e; i++) begin
      @(posedge clk);
    end
    check("out", {16'h0000, out[c]}, {16'h0000, e});
    if (out[c] !== e) begin
      summarize();
    end
  endtask

  // ****************
  // Scenarios
  // ****************
  task automatic t_reset();
    rdc("cfg", 0, OFS_CFG, 32'h00000000);
    rdc("state", 3, OFS_STATE, 32'h00000401);
    rdc("pt1", 1, OFS_POINT0 + 7'h04, 32'h0CCD0000);
    rdc("pt10", 2, OFS_POINT_LAST, 32'h80000000);
    rdc("hdly", 0, OFS_HOT_DLY, 32'h00000000);
  endtask

  task automatic t_map();
    apb(1'b0, 12'h018, 32'h00000000);
    check("hole err", {31'h0, err}, 32'h00000001);
    check("hole data", rd, 32'h00000000);
    apb(1'b1, 12'h200, 32'hFFFFFFFF);
    check("oob err", {31'h0, err}, 32'h00000001);
    wr(0, OFS_STATE, 32'h00000000);
    rdc("state ro", 0, OFS_STATE, 32'h00000401);
    wr(0, OFS_POINT0, 32'hFFFF1234);
    rdc("pt0", 0, OFS_POINT0, 32'h00001234);
    wr(0, OFS_POINT_LAST, 32'h12349000);
    rdc("pt10 clip", 0, OFS_POINT_LAST, 32'h80008000);
    wr(0, OFS_HOT_Y, 32'h0000FFFF);
    rdc("hot y clip", 0, OFS_HOT_Y, 32'h00008000);
    wr(0, OFS_HOT_DLY, 32'h00003FFF);
    rdc("hdly clip", 0, OFS_HOT_DLY, 32'h00002710);
    wait_out(0, 16'h1234);
    wr(0, OFS_CFG, 32'h00000100);
    wait_out(0, 16'h8000);
    rdc("input", 0, OFS_INPUT, 32'h00018000);
  endtask

  task automatic t_interp();
    wr(1, OFS_CFG, 32'h00000001);
    wr(1, OFS_POINT_LAST, 32'h00008000);
    wr(1, OFS_POINT0 + 7'h14, 32'h40002000);
    wr(1, OFS_STATE, 32'h00000421);
    set_src(0, 16'h3001);
    wait_out(1, 16'h1800);
    set_src(0, 16'h6000);
    wait_out(1, 16'h5000);
    wr(1, OFS_STATE, 32'h00000401);
    wait_out(1, 16'h6000);
    check("ch0 kept", {16'h0000, out[0]}, 32'h00008000);
    check("ch3 idle", {16'h0000, out[3]}, 32'h00000000);
    wr(3, OFS_CFG, 32'h00000109);
    rdc("src9", 3, OFS_INPUT, 32'h00018000);
  endtask

  task automatic t_hot();
    int n;
    logic seen;
    wr(2, OFS_CFG, 32'h00000002);
    wr(2, OFS_POINT_LAST, 32'h00006000);
    wr(2, OFS_HOT_Y, 32'h00007000);
    wr(2, OFS_HOT_DLY, 32'h00000008);
    set_src(1, 16'h8000);
    // Delay of 8 ms outlasts two full evaluation passes, so the curve value shows first
    n = 0;
    seen = 1'b0;
    while (n < 200 && hot[2] !== 1'b1) begin
      if (out[2] === 16'h6000 && hot[2] === 1'b0) begin
        seen = 1'b1;
      end
      @(posedge clk);
      n++;
    end
    check("hot early", {31'h0, seen}, 32'h00000001);
    check("hot on", {31'h0, hot[2]}, 32'h00000001);
    check("hot delay", {31'h0, (n > 8 * MS) && (n <= 9 * MS + 1)}, 32'h00000001);
    wait_out(2, 16'h7000);
    rdc("status", 2, OFS_STATUS, 32'h00017000);
    set_src(1, 16'h7FFF);
    repeat (2) @(posedge clk);
    check("hot off", {31'h0, hot[2]}, 32'h00000000);
    wait_out(2, 16'h5FFF);
    set_src(1, 16'h8000);
    wait_out(2, 16'h6000);
    check("hot restart", {31'h0, hot[2]}, 32'h00000000);
    wr(2, OFS_HOT_DLY, 32'h00000000);
    repeat (150) @(posedge clk);
    check("hot disabled", {31'h0, hot[2]}, 32'h00000000);
    check("curve kept", {16'h0000, out[2]}, 32'h00006000);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_map();
    t_interp();
    t_hot();
    summarize();
  end
endmodule
`default_nettype wire
